//--- src/led_pwm_pkg.sv
// package: register map, field layout, timing and carrier types for the led pwm block
package led_pwm_pkg;
  localparam int CH = 36;
  localparam int GROUP_SIZE = 6;
  localparam int GROUPS = 6;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 16_000_000;
  localparam int HZ_UNIT = 1_000_000;
  // register indices; byte address is four times the index
  localparam logic [6:0] R_CTRL = 7'h00;
  localparam logic [6:0] R_DUTY_LO = 7'h01;
  localparam logic [6:0] R_DUTY_HI = 7'h48;
  localparam logic [6:0] R_UPDATE = 7'h49;
  localparam logic [6:0] R_SCALE_LO = 7'h4a;
  localparam logic [6:0] R_SCALE_HI = 7'h6d;
  localparam logic [6:0] R_GLOBAL = 7'h6e;
  localparam logic [6:0] R_PHASE = 7'h70;
  localparam logic [6:0] R_FAULT_SEL = 7'h71;
  localparam logic [6:0] R_FAULT_LO = 7'h72;
  localparam logic [6:0] R_FAULT_HI = 7'h76;
  localparam logic [6:0] R_SPREAD = 7'h78;
  localparam logic [6:0] R_RESET = 7'h7f;
  // field positions
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam int CTRL_DIV_LSB = 4;
  localparam int PHASE_STAGGER_BIT = 7;
  localparam int SPREAD_EN_BIT = 4;
  localparam int SPREAD_RNG_LSB = 2;
  // values
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam logic [7:0] UPDATE_KEY = 8'h00;
  localparam logic [7:0] RESET_KEY = 8'h00;
  localparam logic [1:0] FAULT_SHORT = 2'h2;
  localparam logic [1:0] FAULT_OPEN = 2'h3;

  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [8:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    bus_state_e bus;
    wb_rsp_s rsp;
    logic [7:0] ctrl;
    logic [7:0] global_scale;
    logic [7:0] phase;
    logic [7:0] fault_sel;
    logic [7:0] spread;
    logic [CH-1:0][15:0] shadow;
    logic [CH-1:0][15:0] active;
    logic [CH-1:0][7:0] scale;
    logic [CH-1:0] fault;
    logic [7:0] acc;
    logic [6:0] pre;
    logic [15:0] cnt;
    logic [1:0] hw_sync;
    logic hw_prev;
    logic [CH-1:0] short_s1;
    logic [CH-1:0] short_s2;
    logic [CH-1:0] open_s1;
    logic [CH-1:0] open_s2;
    logic [CH-1:0] led_on;
    logic analog_en;
    logic spread_en;
    logic [1:0] spread_rng;
    logic [CH-1:0][15:0] current_code;
  } state_s;
endpackage

//--- src/led_pwm_channel_control.sv
// led_pwm_channel_control: 36-channel pwm core with wishbone register slave
// Summary of operation
// - each of 36 sink outputs modulated independently, 256/1024/4096/65536 steps
// - duty is a high byte plus a low byte; value four gives step four
// - reset state: 8-bit resolution, 62kHz from 16MHz oscillator, channels share one cycle
// - cycle frequency 1.9Hz to 62kHz from divide field and resolution select
// - no stagger and no edge align: all outputs turn on at cycle start
// - stagger splits outputs into six consecutive groups of six
// - each staggered group starts one sixth period after the previous group
// - edge align bit 0: whole group turns on at cycle start
// - edge align bit 1: even outputs turn off at cycle end instead
// - stagger and edge align work together
// - fault select to 10 captures short results, to 11 open results
// - spread range field selects deviation 5, 15, 24 or 34 percent
// - both shutdown modes keep all configuration and duty registers
// - soft shutdown bit at 0 turns all sinks off, registers stay accessible
// - shutdown pin low disables analog circuits, high ends hardware shutdown
// - rising shutdown pin edge resets the bus interface, keeps registers
// - registers stay readable and writable during hardware shutdown
// - per-channel 8-bit current scale, global scale lowers all outputs
// - peak current is max times global/256 times channel/256
// - new duty values apply only on zero write to update, out of shutdown
module led_pwm_channel_control #(
  parameter int CLK_HZ_P = led_pwm_pkg::CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire led_pwm_pkg::wb_req_s wb_i,
  output led_pwm_pkg::wb_rsp_s wb_o,
  input wire logic hw_shutdown_n_pin_i,
  input wire logic [led_pwm_pkg::CH-1:0] short_detect_i,
  input wire logic [led_pwm_pkg::CH-1:0] open_detect_i,
  output logic [led_pwm_pkg::CH-1:0] led_sink_output_o,
  output logic analog_enable_o,
  output logic spread_enable_o,
  output logic [1:0] spread_range_field_o,
  output logic [led_pwm_pkg::CH-1:0][15:0] current_code_o
);
  import led_pwm_pkg::*;

  localparam logic [7:0] OSC_STEP = 8'(OSC_HZ / HZ_UNIT);
  localparam logic [7:0] CLK_STEP = 8'(CLK_HZ_P / HZ_UNIT);

  if (CLK_HZ_P < OSC_HZ || CLK_HZ_P / HZ_UNIT > 255 || CLK_HZ_P % HZ_UNIT != 0) begin : g_bad_clk
    $error("clock rate cannot derive the modulation oscillator");
  end

  if (GROUPS * GROUP_SIZE != CH) begin : g_bad_groups
    $error("groups do not cover all channels");
  end

  state_s st;
  state_s next_st;
  logic req;
  logic [6:0] idx;
  logic [7:0] d;
  logic wr;
  logic hw_rise;
  logic running;
  logic [7:0] rd;
  logic [6:0] di;
  logic [6:0] si;
  logic [2:0] fi;
  logic [39:0] fault_ext;
  logic [8:0] acc_sum;
  logic osc_tick;
  logic pwm_tick;
  logic [6:0] div_mask;
  logic [15:0] mask;
  logic [15:0] off;
  logic [15:0] pos;
  logic [15:0] duty;
  logic even_out;

  function automatic logic [15:0] res_mask(input logic [1:0] sel);
    case (sel)
      2'h0: res_mask = 16'h00ff;
      2'h1: res_mask = 16'h03ff;
      2'h2: res_mask = 16'h0fff;
      default: res_mask = 16'hffff;
    endcase
  endfunction

  function automatic logic [6:0] div_to_mask(input logic [2:0] n);
    logic [7:0] t;
    t = 8'h01 << n;
    div_to_mask = 7'(t - 8'h01);
  endfunction

  // start offset of a group: group times one sixth of the period
  function automatic logic [15:0] stagger_off(input logic [15:0] m, input logic [2:0] g);
    logic [19:0] p;
    p = ({4'h0, m} + 20'h00001) * {17'h00000, g};
    stagger_off = 16'(p / 20'h00006);
  endfunction

  assign hw_rise = st.hw_sync[1] && !st.hw_prev;
  assign running = st.hw_sync[1] && st.ctrl[CTRL_SOFT_BIT];
  assign req = wb_i.cyc && wb_i.stb;
  assign idx = wb_i.adr[8:2];
  assign d = wb_i.dat[7:0];
  assign wr = req && wb_i.we && wb_i.sel[0] && st.bus == BUS_IDLE && !hw_rise;
  assign di = idx - R_DUTY_LO;
  assign si = idx - R_SCALE_LO;
  assign fi = 3'(idx - R_FAULT_LO);
  assign fault_ext = {4'h0, st.fault};

  // register read mux
  always_comb begin
    rd = REG_DEFAULT;
    if (idx == R_CTRL) begin
      rd = st.ctrl;
    end else if (idx >= R_DUTY_LO && idx <= R_DUTY_HI) begin
      rd = di[0] ? st.shadow[di[6:1]][15:8] : st.shadow[di[6:1]][7:0];
    end else if (idx >= R_SCALE_LO && idx <= R_SCALE_HI) begin
      rd = st.scale[si[5:0]];
    end else if (idx == R_GLOBAL) begin
      rd = st.global_scale;
    end else if (idx == R_PHASE) begin
      rd = st.phase;
    end else if (idx == R_FAULT_SEL) begin
      rd = st.fault_sel;
    end else if (idx >= R_FAULT_LO && idx <= R_FAULT_HI) begin
      rd = fault_ext[{fi, 3'h0} +: 8];
    end else if (idx == R_SPREAD) begin
      rd = st.spread;
    end
  end

  always_comb begin
    next_st = st;
    off = '0;
    pos = '0;
    duty = '0;
    even_out = 1'b0;
    next_st.hw_sync = {st.hw_sync[0], hw_shutdown_n_pin_i};
    next_st.hw_prev = st.hw_sync[1];
    next_st.short_s1 = short_detect_i;
    next_st.short_s2 = st.short_s1;
    next_st.open_s1 = open_detect_i;
    next_st.open_s2 = st.open_s1;
    // bus slave, serves accesses in every shutdown mode
    case (st.bus)
      BUS_IDLE: begin
        if (req) begin
          next_st.bus = BUS_ACK;
          next_st.rsp.ack = 1'b1;
          next_st.rsp.dat = {24'h000000, rd};
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        next_st.rsp.ack = 1'b0;
      end
      default: begin
        next_st.bus = BUS_IDLE;
        next_st.rsp.ack = 1'b0;
      end
    endcase
    if (hw_rise) begin
      next_st.bus = BUS_IDLE;
      next_st.rsp.ack = 1'b0;
    end
    // register writes
    if (wr) begin
      if (idx == R_CTRL) begin
        next_st.ctrl = d;
      end else if (idx >= R_DUTY_LO && idx <= R_DUTY_HI) begin
        if (di[0]) begin
          next_st.shadow[di[6:1]][15:8] = d;
        end else begin
          next_st.shadow[di[6:1]][7:0] = d;
        end
      end else if (idx == R_UPDATE) begin
        if (d == UPDATE_KEY && running) begin
          next_st.active = st.shadow;
        end
      end else if (idx >= R_SCALE_LO && idx <= R_SCALE_HI) begin
        next_st.scale[si[5:0]] = d;
      end else if (idx == R_GLOBAL) begin
        next_st.global_scale = d;
      end else if (idx == R_PHASE) begin
        next_st.phase = d;
      end else if (idx == R_FAULT_SEL) begin
        next_st.fault_sel = {6'h00, d[1:0]};
        if (d[1] && d[1:0] != st.fault_sel[1:0]) begin
          next_st.fault = (d[1:0] == FAULT_OPEN) ? st.open_s2 : st.short_s2;
        end
      end else if (idx == R_SPREAD) begin
        next_st.spread = d;
      end else if (idx == R_RESET && d == RESET_KEY) begin
        next_st.ctrl = REG_DEFAULT;
        next_st.global_scale = REG_DEFAULT;
        next_st.phase = REG_DEFAULT;
        next_st.fault_sel = REG_DEFAULT;
        next_st.spread = REG_DEFAULT;
        next_st.shadow = '0;
        next_st.active = '0;
        next_st.scale = '0;
        next_st.fault = '0;
      end
    end
    // modulation clock from the oscillator rate
    acc_sum = {1'b0, st.acc} + {1'b0, OSC_STEP};
    osc_tick = acc_sum >= {1'b0, CLK_STEP};
    next_st.acc = osc_tick ? 8'(acc_sum - {1'b0, CLK_STEP}) : acc_sum[7:0];
    div_mask = div_to_mask(st.ctrl[CTRL_DIV_LSB +: 3]);
    mask = res_mask(st.ctrl[CTRL_RES_LSB +: 2]);
    pwm_tick = osc_tick && st.pre == div_mask;
    if (osc_tick) begin
      next_st.pre = pwm_tick ? 7'h00 : st.pre + 7'h01;
    end
    if (pwm_tick) begin
      next_st.cnt = (st.cnt >= mask) ? 16'h0000 : st.cnt + 16'h0001;
    end
    // per-channel compare
    for (int i = 0; i < CH; i++) begin
      off = st.phase[PHASE_STAGGER_BIT] ? stagger_off(mask, 3'(i / GROUP_SIZE)) : 16'h0000;
      pos = (st.cnt - off) & mask;
      duty = st.active[i] & mask;
      even_out = st.phase[i / GROUP_SIZE] && (i % 2 == 1);
      if (even_out) begin
        next_st.led_on[i] = running && pos > mask - duty;
      end else begin
        next_st.led_on[i] = running && pos < duty;
      end
      next_st.current_code[i] = {8'h00, st.global_scale} * {8'h00, st.scale[i]};
    end
    next_st.analog_en = st.hw_sync[1];
    next_st.spread_en = st.hw_sync[1] && st.spread[SPREAD_EN_BIT];
    next_st.spread_rng = st.spread[SPREAD_RNG_LSB +: 2];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.bus <= BUS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_o = st.rsp;
  assign led_sink_output_o = st.led_on;
  assign analog_enable_o = st.analog_en;
  assign spread_enable_o = st.spread_en;
  assign spread_range_field_o = st.spread_rng;
  assign current_code_o = st.current_code;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_request;
    st.bus == BUS_IDLE && req && !hw_rise;
  endsequence

  sequence s_update_write;
    wr && idx == R_UPDATE && d == UPDATE_KEY && running;
  endsequence

  sequence s_read_ctrl;
    s_request ##0 (!wb_i.we && idx == R_CTRL);
  endsequence

  sequence s_write_ctrl;
    s_request ##0 (wb_i.we && wb_i.sel[0] && idx == R_CTRL);
  endsequence

  a_ack_single: assert property (s_request |=> wb_o.ack ##1 !wb_o.ack)
    else $error("ack not given for exactly one cycle");

  a_soft_dark: assert property (!st.ctrl[CTRL_SOFT_BIT] |=> led_sink_output_o == '0)
    else $error("sink on during soft shutdown");

  a_hw_dark: assert property (!st.hw_sync[1] |=> !analog_enable_o && led_sink_output_o == '0)
    else $error("analog or sink active during hardware shutdown");

  a_rise_bus_reset: assert property (hw_rise |=> !wb_o.ack && $stable(st.ctrl) && $stable(st.shadow))
    else $error("bus not reset or registers lost on pin rise");

  a_update_copy: assert property (s_update_write |=> st.active == $past(st.shadow))
    else $error("update write did not latch duty values");

  a_no_early_duty: assert property (!(wr && (idx == R_UPDATE || idx == R_RESET)) |=> $stable(st.active))
    else $error("active duty changed without update");

  a_keep_in_off: assert property (!running && !wr |=> $stable(st.ctrl) && $stable(st.scale) && $stable(st.shadow))
    else $error("registers changed during shutdown");

  a_short_capture: assert property (
    wr && idx == R_FAULT_SEL && d[1:0] == FAULT_SHORT && st.fault_sel[1:0] != FAULT_SHORT
    |=> st.fault == $past(st.short_s2))
    else $error("short results not captured");

  a_zero_dark: assert property (st.active[0] == 16'h0000 |=> !led_sink_output_o[0])
    else $error("channel on with zero duty");

  a_current_code: assert property (##1 current_code_o[5] == $past(st.global_scale) * $past(st.scale[5]))
    else $error("current code does not follow scales");

  a_spread_range: assert property (##1 spread_range_field_o == $past(st.spread[SPREAD_RNG_LSB +: 2]))
    else $error("spread range not forwarded");

  a_ctrl_read: assert property (s_read_ctrl
    |=> wb_o.dat == {24'h000000, $past(st.ctrl)})
    else $error("control read returned wrong data");

  a_ctrl_write: assert property (s_write_ctrl
    |=> st.ctrl == $past(d))
    else $error("control write did not land");

  a_ack_needs_req: assert property (!(st.bus == BUS_IDLE && req)
    |=> !wb_o.ack)
    else $error("ack without a request");

  a_phase1_on: assert property (running && (st.cnt & mask) < (st.active[0] & mask)
    |=> led_sink_output_o[0])
    else $error("phase one output off below duty");

  a_phase1_off: assert property (!(running && (st.cnt & mask) < (st.active[0] & mask))
    |=> !led_sink_output_o[0])
    else $error("phase one output on past duty");

  a_phase2_on: assert property (running && st.phase[0] && (st.cnt & mask) > mask - (st.active[1] & mask)
    |=> led_sink_output_o[1])
    else $error("phase two output off near cycle end");

  a_phase2_off: assert property (running && st.phase[0] && (st.cnt & mask) <= mask - (st.active[1] & mask)
    |=> !led_sink_output_o[1])
    else $error("phase two output on too early");

  a_group_sync: assert property (running && st.phase == 8'h00 && st.active[0] == st.active[6]
    && st.active[0] == st.active[35]
    |=> led_sink_output_o[0] == led_sink_output_o[6] && led_sink_output_o[0] == led_sink_output_o[35])
    else $error("outputs with equal duty did not switch together");

  a_cnt_hold: assert property (!pwm_tick
    |=> $stable(st.cnt))
    else $error("cycle counter moved without a tick");

  a_cnt_step: assert property (pwm_tick && st.cnt < mask
    |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("cycle counter did not advance by one");

  a_cnt_wrap: assert property (pwm_tick && st.cnt >= mask
    |=> st.cnt == 16'h0000)
    else $error("cycle counter did not wrap at resolution");

  a_pre_wrap: assert property (pwm_tick
    |=> st.pre == 7'h00)
    else $error("divider not restarted after tick");

  a_global_write: assert property (wr && idx == R_GLOBAL
    |=> st.global_scale == $past(d))
    else $error("global scale write did not land");

  a_scale_write: assert property (wr && idx == R_SCALE_LO + 7'h01
    |=> st.scale[1] == $past(d))
    else $error("channel scale write did not land");

  a_update_gated: assert property (wr && idx == R_UPDATE && !running
    |=> $stable(st.active))
    else $error("update applied during shutdown");

  a_open_capture: assert property (wr && idx == R_FAULT_SEL && d[1:0] == FAULT_OPEN && st.fault_sel[1:0] != FAULT_OPEN
    |=> st.fault == $past(st.open_s2))
    else $error("open results not captured");

  a_fault_kept: assert property (!(wr && (idx == R_FAULT_SEL || idx == R_RESET))
    |=> $stable(st.fault))
    else $error("fault results changed without select write");

  a_spread_gate: assert property (!st.hw_sync[1]
    |=> !spread_enable_o)
    else $error("spread enabled during hardware shutdown");

  a_analog_on: assert property (st.hw_sync[1]
    |=> analog_enable_o)
    else $error("analog not enabled with pin high");
endmodule // led_pwm_channel_control

//--- dv/led_host_model.sv
// host model: classic wishbone master for the register slave
module led_host_model
  import led_pwm_pkg::*;
(
  input wire logic clk_i,
  input wire led_pwm_pkg::wb_rsp_s wb_i,
  output led_pwm_pkg::wb_req_s wb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wb_o = '0;
  // one cycle, request held until ack is sampled high
  task automatic xfer(input logic we, input logic [6:0] idx, input logic [7:0] d, output logic [7:0] q);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0}, sel: 4'hf, dat: {24'h0, d}};
    @(posedge clk_i);
    while (wb_i.ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_i.dat[7:0];
    wb_o.cyc <= 1'b0;
    wb_o.stb <= 1'b0;
    wb_o.dat <= ~wb_o.dat;
    @(posedge clk_i);
  endtask
endmodule // led_host_model

//--- dv/tb_led_pwm_channel_control.sv
// testbench for the led pwm channel control block
module tb_led_pwm_channel_control
  import led_pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hw_pin = 1'b1;
  logic [CH-1:0] short_det = '0;
  logic [CH-1:0] open_det = '0;
  wb_req_s wb_req;
  wb_rsp_s wb_rsp;
  logic [CH-1:0] led;
  logic analog_en;
  logic spread_en;
  logic [1:0] spread_rng;
  logic [CH-1:0][15:0] code;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int on;
  int diff;

  always #5 clk_i = ~clk_i;

  led_pwm_channel_control led_pwm_channel_control_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_i(wb_req), .wb_o(wb_rsp),
    .hw_shutdown_n_pin_i(hw_pin), .short_detect_i(short_det), .open_detect_i(open_det),
    .led_sink_output_o(led), .analog_enable_o(analog_en), .spread_enable_o(spread_en),
    .spread_range_field_o(spread_rng), .current_code_o(code));

  led_host_model led_host_model_i (.clk_i(clk_i), .wb_i(wb_rsp), .wb_o(wb_req));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return {15'h0, v >= lo && v <= hi};
  endfunction

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    led_host_model_i.xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input string what, input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    led_host_model_i.xfer(1'b0, idx, 8'h00, q);
    chk(what, {8'h00, exp}, {8'h00, q});
  endtask

  // counts cycles output a is on and cycles a and b differ
  task automatic measure(input int a, input int b, input int len);
    on = 0;
    diff = 0;
    repeat (len) begin
      @(posedge clk_i);
      on += int'(led[a] === 1'b1);
      diff += int'(led[a] !== led[b]);
    end
  endtask

  task automatic t_reset();
    rd("ctrl", R_CTRL, 8'h00);
    rd("phase", R_PHASE, 8'h00);
    rd("unmapped", 7'h7e, 8'h00);
    chk("analog", 16'h1, {15'h0, analog_en});
    $display("done reset");
  endtask

  task automatic t_duty();
    wr(R_DUTY_LO, 8'h04);
    wr(R_DUTY_LO + 7'h1, 8'h00);
    wr(R_CTRL, 8'h01);
    measure(0, 1, 1600);
    chk("no update", 16'h0, 16'(on));
    wr(R_UPDATE, UPDATE_KEY);
    measure(0, 1, 1600);
    chk("on 8bit", 16'h1, inr(on, 23, 27));
    wr(R_CTRL, 8'h11);
    measure(0, 1, 3200);
    chk("on div2", 16'h1, inr(on, 48, 52));
    wr(R_CTRL, 8'h03);
    measure(0, 1, 6400);
    chk("on 10bit", 16'h1, inr(on, 23, 27));
    wr(R_CTRL, 8'h01);
    for (int k = 1; k < 4; k++) begin
      wr(R_DUTY_LO, 8'(16 * k));
      wr(R_UPDATE, UPDATE_KEY);
      measure(0, 1, 1600);
      chk("breathe", 16'h1, inr(on, 100 * k - 2, 100 * k + 2));
    end
    $display("done duty");
  endtask

  task automatic t_phase();
    wr(R_DUTY_LO, 8'h80);
    wr(R_DUTY_LO + 7'h2, 8'h80);
    wr(R_DUTY_LO + 7'hc, 8'h80);
    wr(R_UPDATE, UPDATE_KEY);
    measure(0, 6, 1600);
    chk("sync", 16'h0, 16'(diff));
    measure(0, 1, 1600);
    chk("phase1", 16'h0, 16'(diff));
    wr(R_PHASE, 8'h80);
    measure(0, 6, 1600);
    chk("stagger", 16'h1, inr(diff, 515, 545));
    measure(0, 1, 1600);
    chk("same group", 16'h0, 16'(diff));
    wr(R_PHASE, 8'h81);
    measure(0, 1, 1600);
    chk("phase2", 16'h1, inr(diff, 1590, 1600));
    wr(R_PHASE, 8'h00);
    $display("done phase");
  endtask

  task automatic t_shut();
    wr(R_CTRL, 8'h00);
    measure(0, 1, 1600);
    chk("soft off", 16'h0, 16'(on));
    rd("duty kept", R_DUTY_LO, 8'h80);
    wr(R_CTRL, 8'h01);
    hw_pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("analog off", 16'h0, {15'h0, analog_en});
    chk("hw dark", 16'h0, led[15:0]);
    wr(R_GLOBAL, 8'h80);
    wr(R_SCALE_LO + 7'h1, 8'hff);
    rd("global hw", R_GLOBAL, 8'h80);
    wr(R_DUTY_LO, 8'h10);
    wr(R_UPDATE, UPDATE_KEY);
    wr(R_CTRL, 8'h01);
    hw_pin <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("analog on", 16'h1, {15'h0, analog_en});
    rd("global kept", R_GLOBAL, 8'h80);
    rd("ctrl kept", R_CTRL, 8'h01);
    chk("code", 16'h7f80, code[1]);
    measure(0, 1, 1600);
    chk("update held", 16'h1, inr(on, 798, 802));
    $display("done shutdown");
  endtask

  task automatic t_clear();
    wr(R_RESET, RESET_KEY);
    rd("ctrl cleared", R_CTRL, 8'h00);
    rd("global cleared", R_GLOBAL, 8'h00);
    rd("fault cleared", R_FAULT_LO, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("code cleared", 16'h0, code[1]);
    chk("spread cleared", 16'h0, {15'h0, spread_en});
    $display("done clear");
  endtask

  task automatic t_fault();
    short_det <= 36'h0_0000_00a5;
    open_det <= 36'h9_0000_003c;
    repeat (4) @(posedge clk_i);
    wr(R_FAULT_SEL, {6'h0, FAULT_SHORT});
    rd("short lo", R_FAULT_LO, 8'ha5);
    rd("short hi", R_FAULT_HI, 8'h00);
    wr(R_FAULT_SEL, {6'h0, FAULT_OPEN});
    rd("open lo", R_FAULT_LO, 8'h3c);
    rd("open hi", R_FAULT_HI, 8'h09);
    $display("done fault");
  endtask

  task automatic t_spread();
    for (int r = 0; r < 4; r++) begin
      wr(R_SPREAD, {3'h0, 1'b1, 2'(r), 2'h0});
      repeat (2) @(posedge clk_i);
      chk("range", 16'(r), {14'h0, spread_rng});
      chk("spread en", 16'h1, {15'h0, spread_en});
    end
    $display("done spread");
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_reset();
    t_duty();
    t_phase();
    t_shut();
    t_fault();
    t_spread();
    t_clear();
    complete_run();
  end
endmodule // tb_led_pwm_channel_control
